// File: rtl/ebrd_consts.vh
// Offsets, field positions, reset values and segment codes of the region decoder
`ifndef EBRD_CONSTS_VH
`define EBRD_CONSTS_VH

// Register byte offsets (APB, one word each)
`define EBRD_OFS_ADDSEL0   12'h000
`define EBRD_OFS_ADDSEL1   12'h004
`define EBRD_OFS_ADDSEL2   12'h008
`define EBRD_OFS_ADDSEL3   12'h00C
`define EBRD_OFS_EMUAS     12'h010
`define EBRD_OFS_BUSCON0   12'h020
`define EBRD_OFS_BUSCON1   12'h024
`define EBRD_OFS_BUSCON2   12'h028
`define EBRD_OFS_BUSCON3   12'h02C
`define EBRD_OFS_EMUBC     12'h030
`define EBRD_OFS_GLOBAL    12'h040
`define EBRD_OFS_STATUS    12'h044

// Address-select fields
`define EBRD_AS_EN_BIT     0
`define EBRD_AS_ALIAS_BIT  1
`define EBRD_AS_LEN_LSB    4
`define EBRD_AS_LEN_MSB    7
`define EBRD_AS_START_LSB  12
`define EBRD_AS_START_MSB  31
`define EBRD_AS_WMASK      32'hFFFF_F0F3

// Bus-control fields
`define EBRD_BC_WREN_BIT   0
`define EBRD_BC_ADDRESS_GENERATION_MODE_LSB   1
`define EBRD_BC_ADDRESS_GENERATION_MODE_MSB   2
`define EBRD_BC_SETUP_BIT  3
`define EBRD_BC_WAITEN_BIT 4
`define EBRD_BC_WAITPOL_BIT 5
`define EBRD_BC_WIDTH_LSB  6
`define EBRD_BC_WIDTH_MSB  7
`define EBRD_BC_ALE_LSB    8
`define EBRD_BC_ALE_MSB    9
`define EBRD_BC_LANE_LSB   10
`define EBRD_BC_LANE_MSB   11
`define EBRD_BC_WRW_LSB    12
`define EBRD_BC_WRW_MSB    14
`define EBRD_BC_RDW_LSB    16
`define EBRD_BC_RDW_MSB    22
`define EBRD_BC_HOLD_LSB   23
`define EBRD_BC_HOLD_MSB   24
`define EBRD_BC_RECOV_LSB  25
`define EBRD_BC_RECOV_MSB  26
`define EBRD_BC_WMUL_LSB   27
`define EBRD_BC_WMUL_MSB   28
`define EBRD_BC_RMUL_LSB   29
`define EBRD_BC_RMUL_MSB   31

// Global settings fields
`define EBRD_GL_MUX_BIT    0

// Reset values: boot region enabled over the lower half of segment 10 (A27 compared as 0)
`define EBRD_RST_ADDSEL0   32'hA000_0001
`define EBRD_RST_ADDSEL    32'h0000_0000
`define EBRD_RST_BUSCON    32'h0000_0001
`define EBRD_RST_GLOBAL    32'h0000_0000

// External segments served
`define EBRD_SEG_CACHED    4'hA
`define EBRD_SEG_ALIAS     4'hB
`define EBRD_SEG_EMU       4'hE

// Compare length limit and fixed compare width
`define EBRD_LEN_MAX       4'hF
`define EBRD_FIXED_MSB     27

`endif

// File: rtl/ebrd_region_decode.v
// Region decode, chip selects, arbitration and slave-start logic of the external bus unit
//
// Overview of operation
// R1: Four user chip selects, one region each
// R2: Region 0 enabled after reset for boot
// R3: Overlap: lowest numbered region wins alone
// R4: Hold request asserted when idle, then grant asserted
// R5: Ownership request when we want bus back
// R6: External master wins bus, then slave access; slave_start does not check bus_release_grant
// R7: Slave select low plus strobe fall starts
// R8: Fetch indicator low for program fetches
// R9: Five regions, each select/control/chip select
// R10: Accept external segment address only when idle
// R11: Disabled region: chip select off, bus error
// R12: Start bits A31..12, segments 10/11/14
// R13: A31..27 always, then length bits from A26
// R14: Length m gives 2^(27-m) byte region
// R15: Aligned start, low bits form offset
// R16: Alias window in segment 11 when enabled
// R17: Unmatched address: error, no external access
// R18: Demux drives A26..0, mux drives 32 bits
// R19: Region control applied, chip select held
// R20: Control register holds all access fields
// R21: Region chosen once, held until done
`timescale 1ns/1ps
`include "ebrd_consts.vh"

module ebrd_region_decode #(
	parameter NUM_USER = 4
) (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB register port
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	// Internal bus request side
	input  wire        req_valid,
	input  wire [31:0] req_addr,
	input  wire        req_write,
	input  wire        req_fetch,
	output wire        req_ready,
	input  wire        acc_done,
	output reg         resp_done,
	output reg         resp_error,
	// Region selects and held settings
	output reg  [3:0]  user_chip_select_n,
	output reg         emulator_region_select_n,
	output reg  [31:0] sel_bus_control,
	output reg  [2:0]  sel_region,
	output reg         access_active,
	output reg  [31:0] ext_addr,
	output reg         fetch_indicator,
	// External bus arbitration
	input  wire        hold_request_n,
	output reg         bus_release_grant,
	output reg         ownership_request,
	// External master access into the chip
	input  wire        internal_bus_slave_select_n,
	input  wire        rd_n,
	input  wire        wr_n,
	input  wire [31:0] ext_addr_in,
	output reg         slave_start,
	output reg         slave_write,
	output reg  [31:0] slave_addr
);

	// Access states
	localparam ST_IDLE = 2'd0;
	localparam ST_ACC  = 2'd1;
	localparam ST_ERR  = 2'd2;

	// Region codes as shown on sel_region
	localparam REG_EMU = 3'd4;
	localparam REG_NONE = 3'd7;

	// Register file: four user regions, then the emulator region
	reg [31:0] addsel_r [0:4];
	reg [31:0] buscon_r [0:4];
	// Global settings and access state
	reg [31:0] global_r;
	reg [1:0]  state_r;
	reg [1:0]  state_nxt;
	// Strobe history for fall detection
	reg        rd_n_q_r;
	reg        wr_n_q_r;
	// Combinational decode results
	reg [2:0]  hit;
	reg        seg_ok;
	integer    k;

	// Start bits valid only in an external segment
	function seg_valid;
		input [3:0] seg;
		begin
			seg_valid = (seg == `EBRD_SEG_CACHED) || (seg == `EBRD_SEG_ALIAS) || (seg == `EBRD_SEG_EMU);
		end
	endfunction

	// Compare address against one region, main window and alias window
	function region_match;
		input [31:0] a;
		input [31:0] as;
		reg   [3:0]  len;
		reg          main_ok;
		reg          alias_ok;
		integer      i;
		begin
			len = as[`EBRD_AS_LEN_MSB:`EBRD_AS_LEN_LSB];
			main_ok = (a[31:`EBRD_FIXED_MSB] == as[31:`EBRD_FIXED_MSB]); // R13
			alias_ok = (a[31:28] == `EBRD_SEG_ALIAS) && (a[27] == as[27]) && as[`EBRD_AS_ALIAS_BIT]; // R16
			// Length m compares m bits down from A26; rest is offset
			for (i = 26; i >= 12; i = i - 1) begin
				if ((26 - i) < len && a[i] != as[i]) begin // R14 R15
					main_ok = 1'b0;
					alias_ok = 1'b0;
				end
			end
			region_match = seg_valid(as[31:28]) && (main_ok || alias_ok); // R12
		end
	endfunction

	// Priority search, first match wins even if disabled
	always @* begin
		hit = REG_NONE;
		for (k = 4; k >= 0; k = k - 1) begin
			if (region_match(req_addr, addsel_r[k])) begin // R3 R9
				hit = k[2:0];
			end
		end
		seg_ok = seg_valid(req_addr[31:28]);
	end

	assign req_ready = (state_r == ST_IDLE) && !bus_release_grant; // R10

	// Access state sequence
	always @* begin
		state_nxt = state_r;
		case (state_r)
			// Take a request in an external segment
			ST_IDLE: begin
				if (req_valid && req_ready && seg_ok) begin // R10
					if (hit == REG_NONE || !addsel_r[hit][`EBRD_AS_EN_BIT]) // R11 R17
						state_nxt = ST_ERR;
					else if (req_write && !buscon_r[hit][`EBRD_BC_WREN_BIT])
						state_nxt = ST_ERR;
					else
						state_nxt = ST_ACC;
				end
			end
			// Hold until the far side ends the access
			ST_ACC: begin
				if (acc_done)
					state_nxt = ST_IDLE; // R21
			end
			// One cycle before the error answer
			ST_ERR: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Access state register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Region, chip select and settings latched at request take
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_chip_select_n <= 4'hF;
			emulator_region_select_n <= 1'b1;
			sel_bus_control <= 32'h0000_0000;
			sel_region <= REG_NONE;
			access_active <= 1'b0;
			ext_addr <= 32'h0000_0000;
			fetch_indicator <= 1'b1;
			resp_done <= 1'b0;
			resp_error <= 1'b0;
		end else begin
			resp_done <= 1'b0;
			resp_error <= 1'b0;
			if (state_r == ST_IDLE && state_nxt == ST_ACC) begin
				sel_region <= hit; // R21
				sel_bus_control <= buscon_r[hit]; // R19 R20
				access_active <= 1'b1;
				fetch_indicator <= !req_fetch; // R8
				if (hit == REG_EMU)
					emulator_region_select_n <= 1'b0;
				else
					user_chip_select_n <= ~(4'h1 << hit[1:0]); // R1 R3
				if (global_r[`EBRD_GL_MUX_BIT])
					ext_addr <= req_addr; // R18
				else
					ext_addr <= {5'h00, req_addr[26:0]}; // R18
			end else if (state_r == ST_IDLE && state_nxt == ST_ERR) begin
				sel_region <= REG_NONE;
			end
			if (state_r == ST_ACC && acc_done) begin
				user_chip_select_n <= 4'hF; // R19
				emulator_region_select_n <= 1'b1;
				access_active <= 1'b0;
				fetch_indicator <= 1'b1;
				resp_done <= 1'b1;
			end
			if (state_r == ST_ERR) begin
				resp_done <= 1'b1;
				resp_error <= 1'b1; // R11 R17
			end
		end
	end

	// External bus arbitration
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_release_grant <= 1'b0;
			ownership_request <= 1'b0;
		end else begin
			// Release only when idle and nothing external is pending
			if (!hold_request_n && state_r == ST_IDLE && !(req_valid && seg_ok)) begin
				bus_release_grant <= 1'b1; // R4
			end else if (hold_request_n) begin
				bus_release_grant <= 1'b0;
			end
			// Ask for the bus back while a request waits
			ownership_request <= bus_release_grant && !hold_request_n && req_valid && seg_ok; // R5
		end
	end

	// Slave access start on strobe fall
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_n_q_r <= 1'b1;
			wr_n_q_r <= 1'b1;
			slave_start <= 1'b0;
			slave_write <= 1'b0;
			slave_addr <= 32'h0000_0000;
		end else begin
			rd_n_q_r <= rd_n;
			wr_n_q_r <= wr_n;
			slave_start <= 1'b0;
			// Select stays live even as general pin
			if (!internal_bus_slave_select_n && ((rd_n_q_r && !rd_n) || (wr_n_q_r && !wr_n))) begin // R6 R7
				slave_start <= 1'b1;
				slave_write <= wr_n_q_r && !wr_n;
				slave_addr <= ext_addr_in;
			end
		end
	end

	// APB register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addsel_r[0] <= `EBRD_RST_ADDSEL0; // R2
			addsel_r[1] <= `EBRD_RST_ADDSEL;
			addsel_r[2] <= `EBRD_RST_ADDSEL;
			addsel_r[3] <= `EBRD_RST_ADDSEL;
			addsel_r[4] <= `EBRD_RST_ADDSEL;
			buscon_r[0] <= `EBRD_RST_BUSCON;
			buscon_r[1] <= `EBRD_RST_BUSCON;
			buscon_r[2] <= `EBRD_RST_BUSCON;
			buscon_r[3] <= `EBRD_RST_BUSCON;
			buscon_r[4] <= `EBRD_RST_BUSCON;
			global_r <= `EBRD_RST_GLOBAL;
		end else if (psel && penable && pwrite) begin
			case (paddr)
				// Address selects, unused bits forced to zero
				`EBRD_OFS_ADDSEL0: begin
					addsel_r[0] <= pwdata & `EBRD_AS_WMASK;
				end
				`EBRD_OFS_ADDSEL1: begin
					addsel_r[1] <= pwdata & `EBRD_AS_WMASK;
				end
				`EBRD_OFS_ADDSEL2: begin
					addsel_r[2] <= pwdata & `EBRD_AS_WMASK;
				end
				`EBRD_OFS_ADDSEL3: begin
					addsel_r[3] <= pwdata & `EBRD_AS_WMASK;
				end
				`EBRD_OFS_EMUAS: begin
					addsel_r[4] <= pwdata & `EBRD_AS_WMASK;
				end
				// Bus controls, every field stored
				`EBRD_OFS_BUSCON0: begin
					buscon_r[0] <= pwdata;
				end
				`EBRD_OFS_BUSCON1: begin
					buscon_r[1] <= pwdata;
				end
				`EBRD_OFS_BUSCON2: begin
					buscon_r[2] <= pwdata;
				end
				`EBRD_OFS_BUSCON3: begin
					buscon_r[3] <= pwdata;
				end
				`EBRD_OFS_EMUBC: begin
					buscon_r[4] <= pwdata;
				end
				// Global settings, mux mode bit only
				`EBRD_OFS_GLOBAL: begin
					global_r <= pwdata & 32'h0000_0001;
				end
				default: begin
				end
			endcase
		end
	end

	assign pready = 1'b1;

	// APB read mux and unmapped error
	always @* begin
		prdata = 32'h0000_0000;
		pslverr = 1'b0;
		case (paddr)
			// Address selects
			`EBRD_OFS_ADDSEL0: begin
				prdata = addsel_r[0];
			end
			`EBRD_OFS_ADDSEL1: begin
				prdata = addsel_r[1];
			end
			`EBRD_OFS_ADDSEL2: begin
				prdata = addsel_r[2];
			end
			`EBRD_OFS_ADDSEL3: begin
				prdata = addsel_r[3];
			end
			`EBRD_OFS_EMUAS: begin
				prdata = addsel_r[4];
			end
			// Bus controls
			`EBRD_OFS_BUSCON0: begin
				prdata = buscon_r[0];
			end
			`EBRD_OFS_BUSCON1: begin
				prdata = buscon_r[1];
			end
			`EBRD_OFS_BUSCON2: begin
				prdata = buscon_r[2];
			end
			`EBRD_OFS_BUSCON3: begin
				prdata = buscon_r[3];
			end
			`EBRD_OFS_EMUBC: begin
				prdata = buscon_r[4];
			end
			// Global settings and live status
			`EBRD_OFS_GLOBAL: begin
				prdata = global_r;
			end
			`EBRD_OFS_STATUS: begin
				prdata = {24'h00_0000, ownership_request, bus_release_grant, sel_region, 1'b0, state_r};
			end
			default:           pslverr = psel && penable;
		endcase
	end

endmodule // ebrd_region_decode

// File: verification/ebrd_chk.sv
// Port-level checks of the region decoder
`timescale 1ns/1ps
module ebrd_chk (
	input logic        pclk, presetn, req_ready, resp_done, resp_error, access_active,
	input logic        emulator_region_select_n, fetch_indicator, hold_request_n, slave_start,
	input logic        bus_release_grant, ownership_request, internal_bus_slave_select_n,
	input logic [3:0]  user_chip_select_n,
	input logic [2:0]  sel_region,
	input logic [31:0] ext_addr_in, slave_addr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_cs_onehot: assert property ($onehot0(~{emulator_region_select_n, user_chip_select_n}))
		else $error("two selects low");
	a_cs_idle: assert property (!access_active |-> &{emulator_region_select_n, user_chip_select_n})
		else $error("select outside access");
	a_cs_match: assert property (access_active && sel_region < 3'h4 |-> !user_chip_select_n[sel_region])
		else $error("wrong select for region");
	a_sel_hold: assert property (access_active && $past(access_active) |-> $stable(sel_region))
		else $error("region changed in access");
	a_err_pair: assert property (resp_error |-> resp_done)
		else $error("error without done");
	a_busy_refuse: assert property (access_active || bus_release_grant |-> !req_ready)
		else $error("ready while busy");
	a_fetch_idle: assert property (!access_active |-> fetch_indicator)
		else $error("fetch low when idle");
	a_grant_cause: assert property ($rose(bus_release_grant) |-> $past(!hold_request_n))
		else $error("grant without hold");
	a_own_cause: assert property (ownership_request |-> $past(bus_release_grant))
		else $error("ownership without grant");
	a_slave_cause: assert property (slave_start |-> $past(!internal_bus_slave_select_n)
		&& slave_addr == $past(ext_addr_in)) else $error("bad slave start");
endmodule // ebrd_chk
bind ebrd_region_decode ebrd_chk chk_u (.*);

// File: verification/ebrd_far_mem.sv
// External memory model ending each access after a set wait
`timescale 1ns/1ps
module ebrd_far_mem (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       access_active,
	input  wire logic [3:0] dly,
	output logic            acc_done
);
	logic [3:0] cnt_r;
	// Count wait states, then one-cycle done
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 4'h0;
			acc_done <= 1'h0;
		end else begin
			acc_done <= 1'h0;
			if (access_active && !acc_done) begin
				cnt_r <= (cnt_r == dly) ? 4'h0 : cnt_r + 4'h1;
				acc_done <= (cnt_r == dly);
			end
		end
	end
endmodule // ebrd_far_mem

// File: verification/external_bus_region_decode_tb_top.sv
// Self-checking bench for the region decoder
`timescale 1ns/1ps
`include "ebrd_consts.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, e); end end
`define WT(c) begin n = 0; while (!(c) && n < 60) begin @(posedge pclk); n++; end \
	if (n >= 60) begin miscompares++; conclude; end end
module external_bus_region_decode_tb_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req_valid = 0, req_write = 0;
	logic        req_fetch = 0, hold_request_n = 1, internal_bus_slave_select_n = 1, rd_n = 1, wr_n = 1;
	logic        pready, pslverr, req_ready, acc_done, resp_done, resp_error, emulator_region_select_n, se, fi;
	logic        access_active, fetch_indicator, bus_release_grant, ownership_request, slave_start, slave_write;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, req_addr = 0, ext_addr_in = 0, prdata, sel_bus_control, ext_addr, slave_addr, q, ea;
	logic [3:0]  user_chip_select_n, dly = 0;
	logic [2:0]  sel_region;
	int          checked = 0, miscompares = 0, n;
	always #5 pclk = ~pclk;
	ebrd_region_decode dut_u (.*);
	ebrd_far_mem mem_u (.pclk, .presetn, .access_active, .dly, .acc_done);
	// Report counts and verdict
	task conclude;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// APB transfer held until pready
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		`WT(pready && penable)
		q = prdata; se = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task rd(input [11:0] a, input [31:0] e); apb(0, a, 0); `CHK(q, e) endtask
	task wr(input [11:0] a, input [31:0] d); apb(1, a, d); endtask
	// Internal request, expected region or error
	task acc(input [31:0] a, input w, input f, input [2:0] r, input e);
		@(posedge pclk);
		`WT(req_ready)
		req_addr <= a; req_write <= w; req_fetch <= f; req_valid <= 1;
		@(posedge pclk);
		req_valid <= 0;
		`WT(access_active || resp_done)
		ea = ext_addr; fi = fetch_indicator;
		if (!e) begin
			`CHK(sel_region, r)
			`CHK(user_chip_select_n, r < 4 ? ~(4'h1 << r) : 4'hF)
			`CHK(emulator_region_select_n, r != 4)
		end
		`WT(resp_done)
		`CHK(resp_error, e)
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		rd(`EBRD_OFS_ADDSEL0, 32'hA000_0001);
		rd(`EBRD_OFS_BUSCON0, 32'h0000_0001);
		apb(0, 12'h0FC, 0);
		`CHK(se, 1'h1)
		wr(`EBRD_OFS_ADDSEL3, 32'hFFFF_FFFF);
		rd(`EBRD_OFS_ADDSEL3, `EBRD_AS_WMASK);
		wr(`EBRD_OFS_ADDSEL3, 32'h0000_0000);
		acc(32'hA000_1234, 0, 0, 0, 0);
		`CHK(ea, 32'h0000_1234)
		`CHK(fi, 1'h1)
		`CHK(sel_bus_control, 32'h0000_0001)
		wr(`EBRD_OFS_ADDSEL1, 32'hA010_00F1);
		acc(32'hA010_0FFC, 1, 0, 0, 0);
		wr(`EBRD_OFS_ADDSEL0, 32'h0000_0000);
		dly <= 4'h5;
		acc(32'hA010_0FFC, 1, 0, 1, 0);
		acc(32'hA010_1000, 0, 0, 0, 1);
		acc(32'hA810_0000, 0, 0, 0, 1);
		acc(32'hA000_0010, 0, 0, 0, 1);
		wr(`EBRD_OFS_ADDSEL2, 32'hA020_00F0);
		acc(32'hA020_0000, 0, 0, 0, 1);
		wr(`EBRD_OFS_ADDSEL1, 32'hA010_00F3);
		acc(32'hB010_0010, 0, 1, 1, 0);
		`CHK(fi, 1'h0)
		wr(`EBRD_OFS_EMUAS, 32'hE000_0001);
		wr(`EBRD_OFS_GLOBAL, 32'h0000_0001);
		acc(32'hE000_0ABC, 1, 0, 4, 0);
		`CHK(ea, 32'hE000_0ABC)
		wr(`EBRD_OFS_BUSCON1, 32'h0000_0000);
		acc(32'hA010_0004, 1, 0, 1, 1);
		acc(32'hA010_0004, 0, 0, 1, 0);
		`CHK(sel_bus_control, 32'h0000_0000)
		hold_request_n <= 0;
		`WT(bus_release_grant)
		`CHK(req_ready, 1'h0)
		req_addr <= 32'hA010_0000; req_valid <= 1;
		`WT(ownership_request)
		`CHK(ownership_request, 1'h1)
		hold_request_n <= 1; req_valid <= 0;
		`WT(!bus_release_grant)
		ext_addr_in <= 32'hD000_0100; internal_bus_slave_select_n <= 0;
		@(posedge pclk);
		wr_n <= 0;
		`WT(slave_start)
		`CHK(slave_addr, 32'hD000_0100)
		`CHK(slave_write, 1'h1)
		wr_n <= 1;
		@(posedge pclk);
		rd_n <= 0;
		`WT(slave_start)
		`CHK(slave_write, 1'h0)
		rd_n <= 1; internal_bus_slave_select_n <= 1;
		conclude;
	end
	// Overall limit on run length
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		conclude;
	end
endmodule // external_bus_region_decode_tb_top
